// ==== logic/level_sync.sv ====
`default_nettype none
// two-stage synchroniser, first stage feeds only the second
module level_sync #(parameter int W = 1) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } st_s;
  st_s st_r;
  st_s st_nxt;
  always_comb begin
    st_nxt.meta = din;
    st_nxt.sync = st_r.meta;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign dout = st_r.sync;
endmodule
`default_nettype wire

// ==== logic/ser_i2c_audio_gpio_status_regs.sv ====
// Overview of operation
// - as local bus master, scl low width comes from the 8-bit low-time field
// - same low-time value is the sda setup interval in slave role
// - one count equals one oscillator clock period, nominally 40 ns
// - scl low phase lasts programmed count plus five clock periods
// - low-time resets to 7Fh, giving at least 5 us low phase
// - bit 7 of audio control blocks automatic repeater audio mode detection
// - read-only bit 3 mirrors the auxiliary audio enable from bridge config
// - bit 0 resets to 1; 1 selects surround, 0 selects 2/4-channel audio
// - surround audio is carried only by the data-island transport
// - in repeater mode detected in-band mode may override surround select
// - back-channel crc errors counted; cleared by link loss, restart, reset
// - error counter is per port; port 1 count read when second port set
// - per-port registers steered by port select for reads; writes to them are ignored
// - status bits 7..5 show pins 7..5; bit 4 reads zero
// - with second port selected, status bits 7..5 read zero
// - bits 3..0 show pins 3..0, or remote pins with second port
// - second status bit 0 shows pin 8; bits 7..1 read zero
// - second port select applies only when secondary address disabled
`default_nettype none
`include "ser_status_regs.svh"
module ser_i2c_audio_gpio_status_regs (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire ser_status_pkg::reg_req_s regReq,
  output logic [7:0]                    rdData,
  input  wire logic                     secondPortSelect,
  input  wire logic                     secondaryAddressEnable,
  input  wire logic                     secondaryAccess,
  input  wire logic                     auxAudioEnable,
  input  wire logic                     repeaterMode,
  input  wire logic                     detectedSurround,
  input  wire logic                     detectValid,
  input  wire logic                     bistActive,
  input  wire logic                     bistRestart,
  input  wire logic                     crcErrorReset,
  input  wire logic [1:0]               linkLost,
  input  wire logic [1:0]               backChannelCrcError,
  input  wire logic [8:0]               pinLevels,
  input  wire logic [3:0]               remotePinLevels,
  input  wire logic                     sclStart,
  input  wire logic                     sclStop,
  input  wire logic                     slaveSetupStart,
  output logic                          sclDriveLow,
  output logic                          slaveSetupDone,
  output logic                          surroundActive,
  output logic                          dataIslandSurround,
  output logic                          autoModeDetectEnable
);
  typedef struct packed {
    logic [7:0]               sclLowPeriod;
    logic                     blockRepeaterMode;
    logic                     surroundSelect;
    logic [1:0][7:0]          errCount;
    ser_status_pkg::scl_state_e sclState;
    logic [8:0]               sclCount;
    logic [8:0]               setupCount;
    logic                     setupBusy;
    logic                     setupDone;
    logic                     sclLow;
    logic                     surroundEff;
    logic [7:0]               rdData;
  } st_s;
  st_s st_r;
  st_s st_nxt;
  logic [8:0] pinSync;
  logic [3:0] remoteSync;
  logic       portOne;
  logic [8:0] lowTarget;
  // pins come from outside the clock domain
  level_sync #(.W(9)) u_pinSync (
    .clk  (clk),
    .nrst (nrst),
    .din  (pinLevels),
    .dout (pinSync)
  );
  level_sync #(.W(4)) u_remoteSync (
    .clk  (clk),
    .nrst (nrst),
    .din  (remotePinLevels),
    .dout (remoteSync)
  );
  // port steering: primary select ignored when second address is on
  always_comb begin
    if (secondaryAddressEnable) begin
      portOne = secondaryAccess;
    end else begin
      portOne = secondPortSelect;
    end
  end
  // programmed count plus the fixed extra periods
  assign lowTarget = {1'b0, st_r.sclLowPeriod}
                     + {1'b0, `SCL_LOW_EXTRA_CYCLES};
  always_comb begin
    st_nxt = st_r;
    st_nxt.setupDone = 1'b0;
    // register writes; read-only offsets ignore writes
    if (regReq.wrEn) begin
      if (regReq.addr == `OFS_SCL_LOW_PERIOD) begin
        st_nxt.sclLowPeriod = regReq.wrData;
      end else if (regReq.addr == `OFS_AUDIO_DP_CONTROL) begin
        st_nxt.blockRepeaterMode =
          regReq.wrData[`BIT_BLOCK_REPEATER_MODE];
        st_nxt.surroundSelect =
          regReq.wrData[`BIT_SURROUND_SELECT];
      end
    end
    // per-port error counters; clear wins, saturate at full scale
    for (int p = 0; p < 2; p++) begin
      if (linkLost[p] || bistRestart || crcErrorReset) begin
        st_nxt.errCount[p] = 8'h00;
      end else if (bistActive && backChannelCrcError[p]
                   && st_r.errCount[p] != 8'hFF) begin
        st_nxt.errCount[p] = st_r.errCount[p] + 8'h01;
      end
    end
    // effective surround: detected mode may override in repeater
    if (repeaterMode && !st_r.blockRepeaterMode && detectValid) begin
      st_nxt.surroundEff = detectedSurround;
    end else begin
      st_nxt.surroundEff = st_r.surroundSelect;
    end
    // master scl generator: low for count+5 cycles, high likewise
    case (st_r.sclState)
      ser_status_pkg::SCL_IDLE: begin
        st_nxt.sclLow = 1'b0;
        if (sclStart) begin
          st_nxt.sclState = ser_status_pkg::SCL_LOW;
          st_nxt.sclCount = 9'h001;
          st_nxt.sclLow = 1'b1;
        end
      end
      ser_status_pkg::SCL_LOW: begin
        // one count per clk cycle, the oscillator period here
        if (st_r.sclCount >= lowTarget) begin
          st_nxt.sclState = ser_status_pkg::SCL_HIGH;
          st_nxt.sclCount = 9'h001;
          st_nxt.sclLow = 1'b0;
        end else begin
          st_nxt.sclCount = st_r.sclCount + 9'h001;
        end
      end
      ser_status_pkg::SCL_HIGH: begin
        if (sclStop) begin
          st_nxt.sclState = ser_status_pkg::SCL_IDLE;
        end else if (st_r.sclCount >= lowTarget) begin
          st_nxt.sclState = ser_status_pkg::SCL_LOW;
          st_nxt.sclCount = 9'h001;
          st_nxt.sclLow = 1'b1;
        end else begin
          st_nxt.sclCount = st_r.sclCount + 9'h001;
        end
      end
      default: begin
        st_nxt.sclState = ser_status_pkg::SCL_IDLE;
        st_nxt.sclLow = 1'b0;
      end
    endcase
    // slave sda setup delay reuses the low-time value
    if (slaveSetupStart && !st_r.setupBusy) begin
      st_nxt.setupBusy = 1'b1;
      st_nxt.setupCount = 9'h001;
    end else if (st_r.setupBusy) begin
      if (st_r.setupCount >= lowTarget) begin
        st_nxt.setupBusy = 1'b0;
        st_nxt.setupDone = 1'b1;
      end else begin
        st_nxt.setupCount = st_r.setupCount + 9'h001;
      end
    end
    // read data registered one cycle after the read strobe
    st_nxt.rdData = 8'h00;
    if (regReq.rdEn) begin
      if (regReq.addr == `OFS_SCL_LOW_PERIOD) begin
        st_nxt.rdData = st_r.sclLowPeriod;
      end else if (regReq.addr == `OFS_AUDIO_DP_CONTROL) begin
        st_nxt.rdData[`BIT_BLOCK_REPEATER_MODE] = st_r.blockRepeaterMode;
        st_nxt.rdData[`BIT_AUX_AUDIO_ACTIVE] = auxAudioEnable;
        st_nxt.rdData[`BIT_SURROUND_SELECT] = st_r.surroundSelect;
      end else if (regReq.addr == `OFS_BC_TEST_ERR_COUNT) begin
        st_nxt.rdData = st_r.errCount[portOne];
      end else if (regReq.addr == `OFS_PIN_LEVEL_LOW) begin
        if (portOne) begin
          st_nxt.rdData = {4'h0, remoteSync};
        end else begin
          st_nxt.rdData = {pinSync[7:5], 1'b0, pinSync[3:0]};
        end
      end else if (regReq.addr == `OFS_PIN_LEVEL_HIGH) begin
        st_nxt.rdData = {7'h00, pinSync[8]};
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.sclLowPeriod <= `RST_SCL_LOW_PERIOD;
      st_r.surroundSelect <= 1'b1;
      st_r.surroundEff <= 1'b1;
      st_r.sclState <= ser_status_pkg::SCL_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end
  // outputs straight from state
  assign rdData = st_r.rdData;
  assign sclDriveLow = st_r.sclLow;
  assign slaveSetupDone = st_r.setupDone;
  assign surroundActive = st_r.surroundEff;
  // surround only rides the data-island transport
  assign dataIslandSurround = st_r.surroundEff;
  assign autoModeDetectEnable = ~st_r.blockRepeaterMode;
endmodule
`default_nettype wire

// ==== logic/ser_status_pkg.sv ====
`default_nettype none
package ser_status_pkg;
  // register access from the serial host side
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } reg_req_s;
  typedef enum logic [1:0] {
    SCL_IDLE = 2'b00,
    SCL_LOW  = 2'b01,
    SCL_HIGH = 2'b10
  } scl_state_e;
endpackage
`default_nettype wire

// ==== logic/ser_status_regs.svh ====
`ifndef SER_STATUS_REGS_SVH
`define SER_STATUS_REGS_SVH
`define OFS_SCL_LOW_PERIOD      8'h19
`define OFS_AUDIO_DP_CONTROL    8'h1A
`define OFS_BC_TEST_ERR_COUNT   8'h1B
`define OFS_PIN_LEVEL_LOW       8'h1C
`define OFS_PIN_LEVEL_HIGH      8'h1D
`define RST_SCL_LOW_PERIOD      8'h7F
`define RST_AUDIO_DP_CONTROL    8'h01
`define BIT_BLOCK_REPEATER_MODE 7
`define BIT_AUX_AUDIO_ACTIVE    3
`define BIT_SURROUND_SELECT     0
`define SCL_LOW_EXTRA_CYCLES    8'h05
`define OSC_PERIOD_NS           40
`endif

// ==== sim/reg_host_model.sv ====
`default_nettype none
module reg_host_model (
  input  wire logic                clk,
  output var ser_status_pkg::reg_req_s regReq,
  input  wire logic [7:0]          rdData
);
  timeunit 1ns;
  timeprecision 1ns;
  initial regReq = '0;
  // strobes last one cycle; data taken at the following falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) regReq <= '{1'b1, 1'b0, a, d};
    @(posedge clk) regReq <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) regReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) regReq <= '0;
    @(negedge clk) d = rdData;
  endtask
endmodule
`default_nettype wire

// ==== sim/ser_i2c_audio_gpio_status_regs_tb.sv ====
`default_nettype none
module ser_i2c_audio_gpio_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, nrst = 1'b0, secondPortSelect = 1'b0;
  logic secondaryAddressEnable = 1'b0, secondaryAccess = 1'b0;
  logic auxAudioEnable = 1'b0, repeaterMode = 1'b0, detectedSurround = 1'b0;
  logic detectValid = 1'b0, bistActive = 1'b0, bistRestart = 1'b0;
  logic crcErrorReset = 1'b0, sclStart = 1'b0, sclStop = 1'b0;
  logic slaveSetupStart = 1'b0;
  logic [1:0] linkLost = 2'h0, backChannelCrcError = 2'h0;
  logic [8:0] pinLevels = 9'h000;
  logic [3:0] remotePinLevels = 4'h0;
  ser_status_pkg::reg_req_s regReq;
  logic [7:0] rdData;
  logic sclDriveLow, slaveSetupDone, surroundActive, dataIslandSurround;
  logic autoModeDetectEnable;
  int err_count = 0;
  int num_checks = 0;
  ser_i2c_audio_gpio_status_regs i_dut (.clk, .nrst, .regReq, .rdData,
    .secondPortSelect, .secondaryAddressEnable, .secondaryAccess,
    .auxAudioEnable, .repeaterMode, .detectedSurround, .detectValid,
    .bistActive, .bistRestart, .crcErrorReset, .linkLost,
    .backChannelCrcError, .pinLevels, .remotePinLevels, .sclStart, .sclStop,
    .slaveSetupStart, .sclDriveLow, .slaveSetupDone, .surroundActive,
    .dataIslandSurround, .autoModeDetectEnable);
  reg_host_model i_host (.clk, .regReq, .rdData);
  initial forever #25 clk = ~clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(a, d);
    chk(d, e);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // a wait that ran out of cycles ends the run
  task automatic lim(input int n);
    if (n >= 300) begin
      err_count++;
      give_verdict();
    end
  endtask
  task automatic t_reset();
    rdchk(8'h19, 8'h7F);
    rdchk(8'h1A, 8'h01);
    rdchk(8'h1B, 8'h00);
    chk({7'h00, autoModeDetectEnable}, 8'h01);
    chk({6'h00, surroundActive, dataIslandSurround}, 8'h03);
  endtask
  task automatic t_rw();
    @(posedge clk) auxAudioEnable <= 1'b1;
    i_host.wr(8'h19, 8'hAA);
    rdchk(8'h19, 8'hAA);
    i_host.wr(8'h1A, 8'hFF);
    rdchk(8'h1A, 8'h89);
    chk({7'h00, autoModeDetectEnable}, 8'h00);
    i_host.wr(8'h1B, 8'h55);
    rdchk(8'h1B, 8'h00);
    i_host.wr(8'h1A, 8'h00);
    rdchk(8'h1A, 8'h08);
    chk({6'h00, surroundActive, dataIslandSurround}, 8'h00);
    // in-band detection overrides surround until bit 7 blocks it
    @(posedge clk) {repeaterMode, detectValid, detectedSurround} <= 3'b111;
    repeat (2) @(negedge clk);
    chk({6'h00, surroundActive, dataIslandSurround}, 8'h03);
    i_host.wr(8'h1A, 8'h80);
    repeat (2) @(negedge clk);
    chk({6'h00, surroundActive, dataIslandSurround}, 8'h00);
    @(posedge clk) {repeaterMode, detectValid, detectedSurround} <= 3'b000;
  endtask
  // short count so one low phase and one setup fit in a few cycles
  task automatic t_scl();
    int n;
    i_host.wr(8'h19, 8'h03);
    @(posedge clk) sclStart <= 1'b1;
    @(posedge clk) sclStart <= 1'b0;
    sclStop <= 1'b1;
    for (n = 0; n < 300; n++) begin
      @(negedge clk);
      if (!sclDriveLow) break;
    end
    lim(n);
    chk(8'(n), 8'h08);
    @(posedge clk) slaveSetupStart <= 1'b1;
    @(posedge clk) slaveSetupStart <= 1'b0;
    for (n = 1; n < 300; n++) begin
      @(negedge clk);
      if (slaveSetupDone) break;
    end
    lim(n);
    chk(8'(n), 8'h09);
  endtask
  task automatic t_err();
    @(posedge clk) bistActive <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) backChannelCrcError <= (k == 3) ? 2'b10 : 2'b01;
      @(posedge clk) backChannelCrcError <= 2'b00;
    end
    rdchk(8'h1B, 8'h03);
    @(posedge clk) secondPortSelect <= 1'b1;
    rdchk(8'h1B, 8'h01);
    @(posedge clk) secondaryAddressEnable <= 1'b1;
    rdchk(8'h1B, 8'h03);
    @(posedge clk) {secondPortSelect, secondaryAddressEnable} <= 2'b00;
    // each of the three clear causes in turn, with a fresh error between
    for (int k = 0; k < 3; k++) begin
      @(posedge clk) {bistRestart, crcErrorReset, linkLost[0]} <= 3'b001 << k;
      @(posedge clk) {bistRestart, crcErrorReset, linkLost[0]} <= 3'b000;
      rdchk(8'h1B, 8'h00);
      @(posedge clk) backChannelCrcError <= 2'b01;
      @(posedge clk) backChannelCrcError <= 2'b00;
    end
  endtask
  task automatic t_pins();
    // mixed levels so a swapped or stuck bit shows; bit 4 pin held high
    @(posedge clk) {pinLevels, remotePinLevels} <= {9'h1B5, 4'hA};
    repeat (3) @(posedge clk);
    rdchk(8'h1C, 8'hA5);
    rdchk(8'h1D, 8'h01);
    @(posedge clk) secondPortSelect <= 1'b1;
    rdchk(8'h1C, 8'h0A);
    @(posedge clk) {secondPortSelect, secondaryAddressEnable} <= 2'b01;
    secondaryAccess <= 1'b1;
    rdchk(8'h1C, 8'h0A);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_rw();
    t_scl();
    t_err();
    t_pins();
    give_verdict();
  end
endmodule
bind ser_i2c_audio_gpio_status_regs status_regs_sva i_sva (.clk, .nrst,
  .regReq, .rdData, .secondPortSelect, .secondaryAddressEnable, .sclDriveLow,
  .slaveSetupStart, .slaveSetupDone, .surroundActive, .dataIslandSurround,
  .autoModeDetectEnable);
`default_nettype wire

// ==== sim/status_regs_sva.sv ====
`default_nettype none
module status_regs_sva (
  input wire logic                     clk,
  input wire logic                     nrst,
  input wire ser_status_pkg::reg_req_s regReq,
  input wire logic [7:0]               rdData,
  input wire logic                     secondPortSelect,
  input wire logic                     secondaryAddressEnable,
  input wire logic                     sclDriveLow,
  input wire logic                     slaveSetupStart,
  input wire logic                     slaveSetupDone,
  input wire logic                     surroundActive,
  input wire logic                     dataIslandSurround,
  input wire logic                     autoModeDetectEnable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] highCnt_r;
  logic [8:0] highCnt_nxt;
  // run length of the low phase; nine bits hold FF plus five
  always_comb highCnt_nxt = sclDriveLow ? highCnt_r + 9'h001 : 9'h000;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) highCnt_r <= 9'h000;
    else highCnt_r <= highCnt_nxt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  scl_low_len_a: assert property (
    $fell(sclDriveLow) |-> highCnt_r >= 9'h005 && highCnt_r <= 9'h104)
    else $error("scl low phase length wrong");
  setup_done_a: assert property (
    slaveSetupStart |-> ##[6:261] slaveSetupDone)
    else $error("setup interval never ended");
  pin_high_zero_a: assert property (
    regReq.rdEn && regReq.addr == 8'h1D |=> rdData[7:1] == 7'h00)
    else $error("upper pin status bits not zero");
  pin_res_zero_a: assert property (
    regReq.rdEn && regReq.addr == 8'h1C |=> rdData[4] == 1'b0)
    else $error("pin status bit 4 not zero");
  port_mask_a: assert property (
    regReq.rdEn && regReq.addr == 8'h1C && secondPortSelect &&
    !secondaryAddressEnable |=> rdData[7:5] == 3'h0)
    else $error("port 1 pin bits not masked");
  audio_res_a: assert property (
    regReq.rdEn && regReq.addr == 8'h1A |=>
    rdData[6:4] == 3'h0 && rdData[2:1] == 2'h0)
    else $error("audio reserved bits not zero");
  auto_detect_a: assert property (
    regReq.rdEn && !regReq.wrEn && regReq.addr == 8'h1A |=>
    rdData[7] == !autoModeDetectEnable)
    else $error("detect enable disagrees with bit 7");
  island_only_a: assert property (
    dataIslandSurround == surroundActive)
    else $error("surround off the data island path");
endmodule
`default_nettype wire
